// file: hw/adcc_top.sv
// converter conversion control with apb register access
//
// How it works
// - any control write aborts the running conversion and starts anew, unless it selects power off
// - without irq enable the done flag is read-only and sets per conversion, in continuous mode on the first only
// - done flag clears on control write or result read
// - with irq enable the done flag is writable; reset clears it
// - with irq enable set, each finished conversion raises an interrupt
// - pending interrupt clears on result read or control write, and also on a status read
// - reset clears the interrupt enable
// - continuous bit converts back to back, updating the result each time
// - continuous bit clear performs one conversion per start then idles
// - reset clears the continuous bit
// - five-bit select; codes zero to seven route port b inputs 0 to 7
// - unused codes give undefined results, left uncontrolled
// - 11101 high reference, 11110 low reference, 11011 factory test
// - all-ones select powers the converter off
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
module adcc_top
    import adcc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // analog front end
    input  wire logic [`ADCC_RES_W-1:0] sample_value,
    output logic [7:0]                  port_b_enable,
    output logic                        high_reference_node_en,
    output logic                        low_reference_node_en,
    output logic                        factory_test_en,
    output logic                        converter_power_on,
    output logic                        sample_strobe,
    // interrupt
    output logic                        irq
);
    // ------------------------------------------------------------------
    // register access
    // ------------------------------------------------------------------
    logic wr_ctrl;
    logic wr_mask;
    logic wr_cycles;
    logic rd_ctrl;
    logic rd_result;

    adcc_apb_slave u_apb (
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pready    (pready),
        .pslverr   (pslverr),
        .wr_ctrl   (wr_ctrl),
        .wr_mask   (wr_mask),
        .wr_cycles (wr_cycles),
        .rd_ctrl   (rd_ctrl),
        .rd_result (rd_result)
    );

    logic [4:0]             input_channel_select_q;
    logic                   conversion_irq_enable_q;
    logic                   continuous_convert_select_q;
    logic                   conversion_done_flag_q;
    logic                   irq_pending_q;
    logic                   irq_mask_q;
    logic [7:0]             conv_cycles_q;
    logic [7:0]             count_q;
    logic [`ADCC_RES_W-1:0] result_q;
    logic                   first_done_q;
    adcc_state_t            state_q;
    logic                   conv_end;
    logic                   powered_off;
    adcc_src_t              source;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            input_channel_select_q      <= 5'(`ADCC_RST_CTRL);
            conversion_irq_enable_q     <= 1'b0;
            continuous_convert_select_q <= 1'b0;
        end else if (wr_ctrl) begin
            input_channel_select_q      <= pwdata[`ADCC_SEL_HI:`ADCC_SEL_LO];
            conversion_irq_enable_q     <= pwdata[`ADCC_BIT_IRQ_EN];
            continuous_convert_select_q <= pwdata[`ADCC_BIT_CONT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_mask_q    <= 1'b1;
            conv_cycles_q <= `ADCC_RST_CYCLES;
        end else begin
            if (wr_mask)
                irq_mask_q <= pwdata[`ADCC_BIT_DONE];
            if (wr_cycles && pwdata[7:0] != 8'h00)
                conv_cycles_q <= pwdata[7:0];
        end
    end

    adcc_mux_decode u_mux (
        .sel                    (input_channel_select_q),
        .port_b_enable          (port_b_enable),
        .high_reference_node_en (high_reference_node_en),
        .low_reference_node_en  (low_reference_node_en),
        .factory_test_en        (factory_test_en),
        .powered_off            (powered_off),
        .source                 (source)
    );

    // unused codes convert whatever the front end returns
    assign converter_power_on = !powered_off;

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    assign conv_end = (state_q == ADCC_SAMPLE) && (count_q == 8'h01);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ADCC_IDLE;
            count_q <= 8'h00;
        end else if (wr_ctrl) begin
            // restart on the new select; power-off code stays idle
            if (pwdata[`ADCC_SEL_HI:`ADCC_SEL_LO] == `ADCC_SEL_POWER_OFF) begin
                state_q <= ADCC_IDLE;
            end else begin
                state_q <= ADCC_SAMPLE;
            end
            count_q <= conv_cycles_q;
        end else begin
            case (state_q)
                ADCC_IDLE: begin
                    count_q <= 8'h00;
                end
                ADCC_SAMPLE: begin
                    if (powered_off)
                        state_q <= ADCC_IDLE;
                    else if (conv_end)
                        state_q <= ADCC_FINISH;
                    count_q <= count_q - 8'h01;
                end
                ADCC_FINISH: begin
                    if (continuous_convert_select_q) begin
                        state_q <= ADCC_SAMPLE;
                        count_q <= conv_cycles_q;
                    end else begin
                        state_q <= ADCC_IDLE;
                    end
                end
                default: state_q <= ADCC_IDLE;
            endcase
        end
    end

    assign sample_strobe = conv_end && !wr_ctrl;

    // result holds until the next completion overwrites it
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            result_q <= '0;
        else if (sample_strobe)
            result_q <= sample_value;
    end

    // ------------------------------------------------------------------
    // done flag and interrupt
    // ------------------------------------------------------------------
    // in continuous mode the flag only reports the first conversion
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            first_done_q <= 1'b0;
        else if (wr_ctrl)
            first_done_q <= 1'b0;
        else if (sample_strobe)
            first_done_q <= 1'b1;
    end

    // set wins over a same-cycle clear from a result read
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            conversion_done_flag_q <= 1'b0;
        else if (wr_ctrl)
            conversion_done_flag_q <= conversion_irq_enable_q &&
                                      pwdata[`ADCC_BIT_IRQ_EN] &&
                                      pwdata[`ADCC_BIT_DONE];
        else if (sample_strobe &&
                 !(continuous_convert_select_q && first_done_q))
            conversion_done_flag_q <= 1'b1;
        else if (rd_result)
            conversion_done_flag_q <= 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            irq_pending_q <= 1'b0;
        else if (sample_strobe && conversion_irq_enable_q)
            irq_pending_q <= 1'b1;
        else if (wr_ctrl || rd_result || rd_ctrl)
            irq_pending_q <= 1'b0;
    end

    assign irq = irq_pending_q && irq_mask_q;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `ADCC_OFF_STATUS_CTRL: begin
                prdata[`ADCC_BIT_DONE]   = conversion_done_flag_q;
                prdata[`ADCC_BIT_IRQ_EN] = conversion_irq_enable_q;
                prdata[`ADCC_BIT_CONT]   = continuous_convert_select_q;
                prdata[`ADCC_SEL_HI:`ADCC_SEL_LO] = input_channel_select_q;
            end
            `ADCC_OFF_RESULT:      prdata[`ADCC_RES_W-1:0] = result_q;
            `ADCC_OFF_IRQ_MASK:    prdata[`ADCC_BIT_DONE] = irq_mask_q;
            `ADCC_OFF_CONV_CYCLES: prdata[7:0] = conv_cycles_q;
            default:               prdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_write_restarts: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_ctrl && pwdata[`ADCC_SEL_HI:`ADCC_SEL_LO] != `ADCC_SEL_POWER_OFF
        |=> state_q == ADCC_SAMPLE)
        else $error("control write did not restart conversion");
    a_done_sets: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        sample_strobe && !continuous_convert_select_q
        |=> conversion_done_flag_q)
        else $error("done flag missed a conversion");
    // later conversions of a continuous run leave the flag alone
    a_cont_flag_once: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        sample_strobe && continuous_convert_select_q && first_done_q &&
        !rd_result |=> conversion_done_flag_q == $past(conversion_done_flag_q))
        else $error("done flag set again in continuous mode");
    a_done_clears: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_result && !sample_strobe && !wr_ctrl
        |=> !conversion_done_flag_q)
        else $error("done flag not cleared by result read");
    a_irq_raised: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        sample_strobe && conversion_irq_enable_q
        |=> irq_pending_q)
        else $error("interrupt not raised at conversion end");
    a_irq_withdrawn: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_ctrl
        |=> !irq_pending_q)
        else $error("interrupt not withdrawn on control write");
    a_read_drops_irq: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_result && !(sample_strobe && conversion_irq_enable_q)
        |=> !irq_pending_q)
        else $error("interrupt not withdrawn on result read");
    a_single_idles: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state_q == ADCC_FINISH && !continuous_convert_select_q && !wr_ctrl
        |=> state_q == ADCC_IDLE ##1 (state_q == ADCC_IDLE || $past(wr_ctrl)))
        else $error("single mode did not idle");
    a_cont_repeats: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state_q == ADCC_FINISH && continuous_convert_select_q && !wr_ctrl
        |=> state_q == ADCC_SAMPLE)
        else $error("continuous mode stopped");
    // the strobe is a single-cycle capture pulse per conversion
    a_strobe_pulse: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        sample_strobe
        |=> !sample_strobe)
        else $error("sample strobe longer than one cycle");
    a_result_holds: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !sample_strobe
        |=> result_q == $past(result_q))
        else $error("result changed without a conversion");
    a_power_off: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        input_channel_select_q == `ADCC_SEL_POWER_OFF
        |-> !converter_power_on)
        else $error("converter powered with off code");
    a_off_stays_idle: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        powered_off && !wr_ctrl
        |=> state_q == ADCC_IDLE)
        else $error("sequencer ran while powered off");
    a_reset_ctrl: assert property (
        @(posedge clk_sys)
        !rst_n
        |=> !conversion_irq_enable_q && !continuous_convert_select_q)
        else $error("reset left enables set");
endmodule : adcc_top
`default_nettype wire

// file: hw/adcc_cfg.svh
// constants for the converter control block
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
// register byte offsets
`define ADCC_OFF_STATUS_CTRL 12'h000
`define ADCC_OFF_RESULT      12'h004
`define ADCC_OFF_IRQ_MASK    12'h008
`define ADCC_OFF_CONV_CYCLES 12'h00c
// status/control field positions
`define ADCC_BIT_DONE        7
`define ADCC_BIT_IRQ_EN      6
`define ADCC_BIT_CONT        5
`define ADCC_SEL_HI          4
`define ADCC_SEL_LO          0
// reset values
`define ADCC_RST_CTRL        8'h1f
`define ADCC_RST_CYCLES      8'h10
// select codes
`define ADCC_SEL_LAST_PORT   5'h07
`define ADCC_SEL_FACTORY     5'h1b
`define ADCC_SEL_REF_HIGH    5'h1d
`define ADCC_SEL_REF_LOW     5'h1e
`define ADCC_SEL_POWER_OFF   5'h1f
// converter result width
`define ADCC_RES_W           10
`endif

// file: hw/adcc_pkg.sv
// types shared by the converter control block
package adcc_pkg;
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_SAMPLE,
        ADCC_FINISH
    } adcc_state_t;

    typedef enum logic [2:0] {
        ADCC_SRC_PORT,
        ADCC_SRC_REF_HIGH,
        ADCC_SRC_REF_LOW,
        ADCC_SRC_FACTORY,
        ADCC_SRC_UNUSED,
        ADCC_SRC_OFF
    } adcc_src_t;
endpackage : adcc_pkg

// file: hw/adcc_mux_decode.sv
// input select decoder for the converter multiplexer
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
module adcc_mux_decode
    import adcc_pkg::*;
(
    // select code
    input  wire logic [4:0] sel,
    // decoded routing
    output logic [7:0]      port_b_enable,
    output logic            high_reference_node_en,
    output logic            low_reference_node_en,
    output logic            factory_test_en,
    output logic            powered_off,
    output adcc_src_t       source
);
    function automatic adcc_src_t adcc_classify(input logic [4:0] s);
        if (s <= `ADCC_SEL_LAST_PORT)
            return ADCC_SRC_PORT;
        else if (s == `ADCC_SEL_REF_HIGH)
            return ADCC_SRC_REF_HIGH;
        else if (s == `ADCC_SEL_REF_LOW)
            return ADCC_SRC_REF_LOW;
        else if (s == `ADCC_SEL_FACTORY)
            return ADCC_SRC_FACTORY;
        else if (s == `ADCC_SEL_POWER_OFF)
            return ADCC_SRC_OFF;
        else
            return ADCC_SRC_UNUSED;
    endfunction : adcc_classify

    always_comb begin
        source = adcc_classify(sel);
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_port
            // codes zero to seven route port b inputs in order
            assign port_b_enable[gi] = (source == ADCC_SRC_PORT) &&
                                       (sel[2:0] == 3'(gi));
        end
    endgenerate

    assign high_reference_node_en = (source == ADCC_SRC_REF_HIGH);
    assign low_reference_node_en  = (source == ADCC_SRC_REF_LOW);
    assign factory_test_en        = (source == ADCC_SRC_FACTORY);
    assign powered_off            = (source == ADCC_SRC_OFF);

    // each code is checked as it is left, on its settled decode
    a_off_only_all_ones: assert property (
        @(sel) powered_off |-> (sel == `ADCC_SEL_POWER_OFF))
        else $error("power off decoded from a wrong code");
endmodule : adcc_mux_decode
`default_nettype wire

// file: hw/adcc_apb_slave.sv
// apb access decoder for the converter control registers
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
module adcc_apb_slave
    import adcc_pkg::*;
(
    // apb side
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    output logic             pready,
    output logic             pslverr,
    // decoded strobes
    output logic             wr_ctrl,
    output logic             wr_mask,
    output logic             wr_cycles,
    output logic             rd_ctrl,
    output logic             rd_result
);
    logic access;
    logic mapped;

    assign access  = psel && penable;
    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign mapped  = (paddr == `ADCC_OFF_STATUS_CTRL) ||
                     (paddr == `ADCC_OFF_RESULT) ||
                     (paddr == `ADCC_OFF_IRQ_MASK) ||
                     (paddr == `ADCC_OFF_CONV_CYCLES);
    assign pslverr = access && !mapped;
    assign wr_ctrl   = access && pwrite && (paddr == `ADCC_OFF_STATUS_CTRL);
    assign wr_mask   = access && pwrite && (paddr == `ADCC_OFF_IRQ_MASK);
    assign wr_cycles = access && pwrite && (paddr == `ADCC_OFF_CONV_CYCLES);
    assign rd_ctrl   = access && !pwrite && (paddr == `ADCC_OFF_STATUS_CTRL);
    assign rd_result = access && !pwrite && (paddr == `ADCC_OFF_RESULT);
endmodule : adcc_apb_slave
`default_nettype wire

// file: bench/adcc_front_model.sv
// analog front end model: port b inputs and reference nodes
`timescale 1ns/10ps
`default_nettype none
module adcc_front_model (
    // clock
    input  wire logic       clk_sys,
    // routing from the block
    input  wire logic [7:0] port_b_enable,
    input  wire logic       high_reference_node_en,
    input  wire logic       low_reference_node_en,
    input  wire logic       converter_power_on,
    input  wire logic [9:0] chan_base,
    // converter output
    output logic [9:0]      sample_value
);
    logic [9:0] junk_q = 10'h2a5;

    // changes every cycle so nothing unrouted can look like a real sample
    always_ff @(posedge clk_sys) begin
        junk_q <= junk_q + 10'h137;
    end

    always_comb begin
        sample_value = junk_q;
        if (converter_power_on) begin
            for (int i = 0; i < 8; i++) begin
                if (port_b_enable[i]) sample_value = chan_base + 10'(i);
            end
            if (high_reference_node_en) sample_value = 10'h3ff;
            if (low_reference_node_en) sample_value = 10'h000;
        end
    end
endmodule : adcc_front_model
`default_nettype wire

// file: bench/tb_adc_conversion_control.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
module tb_adc_conversion_control;
    import adcc_pkg::*;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } adcc_exp_t;
    localparam logic [11:0] CTRL = `ADCC_OFF_STATUS_CTRL;
    localparam logic [11:0] RES  = `ADCC_OFF_RESULT;
    localparam logic [11:0] MASK = `ADCC_OFF_IRQ_MASK;
    localparam int          N    = 16;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0]  sample_value, chan_base;
    logic [7:0]  port_b_enable;
    logic        ref_hi, ref_lo, fact_en, power_on, sample_strobe, irq;
    adcc_exp_t   expq[$];
    adcc_exp_t   cur;
    int          errors, cmp_count, strobes, n, s0;

    adcc_top adcc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_value(sample_value), .port_b_enable(port_b_enable),
        .high_reference_node_en(ref_hi), .low_reference_node_en(ref_lo),
        .factory_test_en(fact_en), .converter_power_on(power_on),
        .sample_strobe(sample_strobe), .irq(irq));
    adcc_front_model adcc_front_model_i (.clk_sys(clk_sys),
        .port_b_enable(port_b_enable), .high_reference_node_en(ref_hi),
        .low_reference_node_en(ref_lo), .converter_power_on(power_on),
        .chan_base(chan_base), .sample_value(sample_value));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ---------------------------------------------------------------
    // bus tasks and checking
    // ---------------------------------------------------------------
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            errors++;
            print_verdict();
        end
        @(posedge clk_sys);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic err);
        expq.push_back('{data: e & m, mask: m, err: err});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic wait_strobe();
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (sample_strobe !== 1'b1 && n < 200);
        if (n >= 200) begin
            errors++;
            print_verdict();
        end
    endtask : wait_strobe

    // read data checked at the edge the master takes it
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            cur = expq.pop_front();
            cmp(prdata & cur.mask, cur.data);
            cmp(32'(pslverr), 32'(cur.err));
        end
        if (sample_strobe === 1'b1) strobes <= strobes + 1;
    end

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, rst_n} = 4'h0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        chan_base = 10'h000;
        void'($urandom(32'hd97d0fc5));
        repeat (8) @(posedge clk_sys);
        rst_n     <= 1'b1;
        chan_base <= 10'($urandom);
        @(posedge clk_sys);
        rd(CTRL, 32'h1f, 32'hff, 1'b0);
        cmp(32'(power_on), 32'h0);
        rd(12'h010, 32'h0, 32'h0, 1'b1);
        apb(1'b1, CTRL, 32'h08);
        cmp(32'(port_b_enable), 32'h0);
        // first result after power off is discarded while it settles
        apb(1'b1, CTRL, 32'h1d);
        wait_strobe();
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, CTRL, k ? 32'h1e : 32'h1d);
            cmp(32'({ref_hi, ref_lo}), k ? 32'h1 : 32'h2);
            wait_strobe();
            repeat (2) @(posedge clk_sys);
            rd(RES, k ? 32'h0 : 32'h3ff, 32'h3ff, 1'b0);
        end
        s0 = strobes;
        repeat (3 * N) @(posedge clk_sys);
        cmp(32'(strobes - s0), 32'h0);
        apb(1'b1, CTRL, 32'h1b);
        cmp(32'(fact_en), 32'h1);
        for (int ch = 0; ch < 8; ch++) begin
            apb(1'b1, CTRL, 32'(ch));
            cmp(32'(port_b_enable), 32'(8'h1 << ch));
            wait_strobe();
            repeat (2) @(posedge clk_sys);
            rd(CTRL, 32'h80 | ch, 32'hff, 1'b0);
            rd(RES, 32'(chan_base + 10'(ch)), 32'h3ff, 1'b0);
            rd(CTRL, 32'(ch), 32'hff, 1'b0);
        end
        apb(1'b1, CTRL, 32'h1f);
        cmp(32'(power_on), 32'h0);
        repeat (N + 4) @(posedge clk_sys);
        rd(RES, 32'(chan_base + 10'h7), 32'h3ff, 1'b0);
        // continuous mode
        apb(1'b1, CTRL, 32'h22);
        s0 = strobes;
        repeat (4 * N + 8) @(posedge clk_sys);
        cmp(32'(strobes - s0 >= 3), 32'h1);
        rd(CTRL, 32'ha2, 32'hff, 1'b0);
        rd(RES, 32'(chan_base + 10'h2), 32'h3ff, 1'b0);
        // later conversions refresh the result but leave the flag clear
        chan_base <= chan_base + 10'h155;
        repeat (2 * N + 4) @(posedge clk_sys);
        rd(CTRL, 32'h22, 32'hff, 1'b0);
        rd(RES, 32'(chan_base + 10'h2), 32'h3ff, 1'b0);
        // abort: a second write restarts the count
        apb(1'b1, CTRL, 32'h00);
        repeat (N / 2) @(posedge clk_sys);
        apb(1'b1, CTRL, 32'h01);
        wait_strobe();
        cmp(32'(n >= N - 2), 32'h1);
        repeat (2) @(posedge clk_sys);
        rd(RES, 32'(chan_base + 10'h1), 32'h3ff, 1'b0);
        // interrupt raise, mask, clear
        apb(1'b1, CTRL, 32'h43);
        wait_strobe();
        repeat (3) @(posedge clk_sys);
        cmp(32'(irq), 32'h1);
        apb(1'b1, MASK, 32'h0);
        cmp(32'(irq), 32'h0);
        apb(1'b1, MASK, 32'h80);
        cmp(32'(irq), 32'h1);
        rd(RES, 32'(chan_base + 10'h3), 32'h3ff, 1'b0);
        cmp(32'(irq), 32'h0);
        apb(1'b1, CTRL, 32'h43);
        wait_strobe();
        repeat (3) @(posedge clk_sys);
        cmp(32'(irq), 32'h1);
        apb(1'b1, CTRL, 32'h43);
        cmp(32'(irq), 32'h0);
        // flag writable only while interrupts are enabled
        apb(1'b1, CTRL, 32'hc3);
        rd(CTRL, 32'hc3, 32'hff, 1'b0);
        apb(1'b1, CTRL, 32'h83);
        apb(1'b1, CTRL, 32'h83);
        rd(CTRL, 32'h03, 32'hff, 1'b0);
        // reset again in mid-conversion with both enables set
        apb(1'b1, CTRL, 32'h63);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(CTRL, 32'h1f, 32'hff, 1'b0);
        cmp(32'(irq), 32'h0);
        apb(1'b1, 12'h00c, 32'h0);
        rd(12'h00c, 32'h10, 32'hff, 1'b0);
        rd(MASK, 32'h80, 32'hff, 1'b0);
        cmp(32'(expq.size()), 32'h0);
        print_verdict();
    end
endmodule : tb_adc_conversion_control
`default_nettype wire
